// file: logic/bfpc_pkg.sv
// Package: register map, field layout and event codes for the perf counters
package bfpc_pkg;

    // Register byte offsets
    localparam logic [7:0] BFPC_OFS_COUNT_TWO = 8'h18;
    localparam logic [7:0] BFPC_OFS_SELECT_TWO = 8'h1C;
    localparam logic [7:0] BFPC_OFS_COUNT_THREE = 8'h20;
    localparam logic [7:0] BFPC_OFS_SELECT_THREE = 8'h24;

    // Field layout
    localparam int BFPC_COUNT_W = 24;
    localparam int BFPC_SEL_W = 5;
    localparam int BFPC_NUM_PORTS = 10;
    localparam int BFPC_NUM_CTR = 2;

    // Reset values and counter saturation limit
    localparam logic [23:0] BFPC_COUNT_RST = 24'h000000;
    localparam logic [23:0] BFPC_COUNT_MAX = 24'hFFFFFF;
    localparam logic [4:0] BFPC_SEL_RST = 5'h1F;

    // Highest documented selector code
    localparam logic [4:0] BFPC_SEL_LAST = 5'h13;

    // AXI response codes
    localparam logic [1:0] BFPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] BFPC_RESP_SLVERR = 2'h2;

    // Port index order of the event vectors, bit 0 first
    typedef enum logic [3:0] {
        BFPC_PORT_PERIPH = 4'h0,
        BFPC_PORT_FAST_PERIPH = 4'h1,
        BFPC_PORT_SRAM5 = 4'h2,
        BFPC_PORT_SRAM4 = 4'h3,
        BFPC_PORT_SRAM3 = 4'h4,
        BFPC_PORT_SRAM2 = 4'h5,
        BFPC_PORT_SRAM1 = 4'h6,
        BFPC_PORT_SRAM0 = 4'h7,
        BFPC_PORT_XIP = 4'h8,
        BFPC_PORT_ROM = 4'h9
    } bfpc_port_e;

    // Arbiter event inputs, one bit per downstream port
    typedef struct packed {
        logic [9:0] contended;
        logic [9:0] access;
    } bfpc_events_s;

    // Register write request handed to the counters
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
    } bfpc_wreq_s;

endpackage : bfpc_pkg

// file: logic/bfpc_event_mux.sv
// Event selector decode: picks one arbiter event per selector code up to BFPC_SEL_LAST, none above it
`timescale 1ns/10ps
module bfpc_event_mux (
    input wire logic [bfpc_pkg::BFPC_SEL_W-1:0] sel,
    input wire bfpc_pkg::bfpc_events_s events,
    output logic hit
);
    import bfpc_pkg::*;

    // Port index is code/2, low bit picks all vs contended
    always_comb
    begin
        hit = 1'b0;
        if (sel <= BFPC_SEL_LAST)
        begin
            if (sel[0])
                hit = events.access[sel[4:1]];
            else
                hit = events.contended[sel[4:1]];
        end
    end

endmodule : bfpc_event_mux

// file: logic/bfpc_counter.sv
// One saturating counter, cleared by a software write
`timescale 1ns/10ps
module bfpc_counter (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic inc,
    output logic [bfpc_pkg::BFPC_COUNT_W-1:0] count
);
    import bfpc_pkg::*;

    // Clear outranks a same-cycle event: software asked for zero
    always_ff @(posedge ref_clk)
    begin
        if (rst || clear)
            count <= BFPC_COUNT_RST;
        else if (inc && count != BFPC_COUNT_MAX)
            count <= count + 24'h000001;
    end

    sat_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (count == BFPC_COUNT_MAX && !clear) |=> count == BFPC_COUNT_MAX)
        else $error("counter left saturation without clear");

    clear_zero_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        clear |=> count == BFPC_COUNT_RST)
        else $error("counter not zero after clear");

    inc_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        (inc && !clear && count != BFPC_COUNT_MAX)
        |=> count == $past(count) + 24'h000001)
        else $error("counter missed an event");

    idle_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!inc && !clear) |=> $stable(count))
        else $error("counter moved without event");

endmodule : bfpc_counter

// file: logic/bfpc_top.sv
// Bus fabric performance counters two and three behind AXI4-Lite
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module bfpc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire bfpc_pkg::bfpc_events_s events,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import bfpc_pkg::*;

    // Write channel holding state
    logic aw_held_r; // Address captured
    logic w_held_r; // Data captured
    logic [7:0] awaddr_r; // Captured write address
    logic [31:0] wdata_r; // Captured write data
    logic [3:0] wstrb_r; // Captured strobes
    bfpc_wreq_s wreq; // Write request this cycle

    // Selector registers
    logic [BFPC_SEL_W-1:0] sel_two_r;
    logic [BFPC_SEL_W-1:0] sel_three_r;

    // Counter values and increments
    logic [BFPC_COUNT_W-1:0] count_two;
    logic [BFPC_COUNT_W-1:0] count_three;
    logic hit_two;
    logic hit_three;

    // Word decode used by the write response path; reads decode in their own case
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == BFPC_OFS_COUNT_TWO) ||
                     (a == BFPC_OFS_SELECT_TWO) ||
                     (a == BFPC_OFS_COUNT_THREE) ||
                     (a == BFPC_OFS_SELECT_THREE);
    endfunction : addr_known

    // Address and data accepted in either order
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            aw_held_r <= 1'b0;
            awaddr_r <= 8'h00;
        end
        else if (wreq.wr)
            aw_held_r <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr[7:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end
        else if (wreq.wr)
            w_held_r <= 1'b0;
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
    end

    // Ready while that half is empty and no response pending
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !s_axi_bvalid &&
                             !(s_axi_awvalid && s_axi_awready) && !wreq.wr;
            s_axi_wready <= !w_held_r && !s_axi_bvalid &&
                            !(s_axi_wvalid && s_axi_wready) && !wreq.wr;
        end
    end

    // Commit once both halves are held, one cycle pulse
    always_comb
    begin
        wreq.wr = aw_held_r && w_held_r && !s_axi_bvalid;
        wreq.addr = {awaddr_r[7:2], 2'b00};
        wreq.data = wdata_r;
    end

    // Write response; unmapped word answers SLVERR
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= BFPC_RESP_OKAY;
        end
        else if (wreq.wr)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_known(wreq.addr) ? BFPC_RESP_OKAY
                                                 : BFPC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Selector storage; only low byte lane carries the field
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sel_two_r <= BFPC_SEL_RST;
            sel_three_r <= BFPC_SEL_RST;
        end
        else if (wreq.wr && wstrb_r[0])
        begin
            if (wreq.addr == BFPC_OFS_SELECT_TWO)
                sel_two_r <= wreq.data[BFPC_SEL_W-1:0];
            if (wreq.addr == BFPC_OFS_SELECT_THREE)
                sel_three_r <= wreq.data[BFPC_SEL_W-1:0];
        end
    end

    bfpc_event_mux u_mux_two (
        .sel(sel_two_r),
        .events(events),
        .hit(hit_two)
    );

    bfpc_event_mux u_mux_three (
        .sel(sel_three_r),
        .events(events),
        .hit(hit_three)
    );

    bfpc_counter u_count_two (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(wreq.wr && wreq.addr == BFPC_OFS_COUNT_TWO),
        .inc(hit_two),
        .count(count_two)
    );

    bfpc_counter u_count_three (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(wreq.wr && wreq.addr == BFPC_OFS_COUNT_THREE),
        .inc(hit_three),
        .count(count_three)
    );

    // Read channel: accept when idle, answer next cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s_axi_arready <= 1'b0;
        else
            s_axi_arready <= !s_axi_rvalid &&
                             !(s_axi_arvalid && s_axi_arready);
    end

    // Read data; reserved bits read zero
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= BFPC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= BFPC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                BFPC_OFS_COUNT_TWO: s_axi_rdata <= {8'h00, count_two};
                BFPC_OFS_SELECT_TWO: s_axi_rdata <= {27'h0, sel_two_r};
                BFPC_OFS_COUNT_THREE: s_axi_rdata <= {8'h00, count_three};
                BFPC_OFS_SELECT_THREE: s_axi_rdata <= {27'h0, sel_three_r};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= BFPC_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    sel_reset_a: assert property (@(posedge ref_clk)
        $fell(rst) |-> sel_two_r == BFPC_SEL_RST &&
            sel_three_r == BFPC_SEL_RST)
        else $error("selector not all ones after reset");

    rom_code_a: assert property (@(posedge ref_clk) disable iff (rst)
        sel_two_r == 5'h13 |-> hit_two == events.access[BFPC_PORT_ROM])
        else $error("code 0x13 not mapped to rom access");

    fast_contend_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        sel_three_r == 5'h02 |-> hit_three ==
            events.contended[BFPC_PORT_FAST_PERIPH])
        else $error("code 0x02 not contended fast port");

    dead_code_a: assert property (@(posedge ref_clk) disable iff (rst)
        sel_two_r > BFPC_SEL_LAST |-> !hit_two)
        else $error("out of range code counted");

    read_pad_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
        else $error("reserved read bits not zero");

    write_resp_a: assert property (@(posedge ref_clk) disable iff (rst)
        wreq.wr |=> s_axi_bvalid)
        else $error("write response missing");

    // Write channel shut while answer stands
    write_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");

    // Read channel shut while data stands
    read_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");

    // Unmapped write answers error
    bad_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wreq.wr && !addr_known(wreq.addr))
        |=> s_axi_bresp == BFPC_RESP_SLVERR)
        else $error("unmapped write not refused");

    sel_store_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wreq.wr && wstrb_r[0] && wreq.addr == BFPC_OFS_SELECT_TWO)
        |=> sel_two_r == $past(wreq.data[BFPC_SEL_W-1:0]))
        else $error("selector two missed its write");

    sel_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(wreq.wr && wstrb_r[0] && wreq.addr == BFPC_OFS_SELECT_THREE)
        |=> $stable(sel_three_r))
        else $error("selector three moved without write");

    xip_all_a: assert property (@(posedge ref_clk) disable iff (rst)
        sel_three_r == 5'h11 |-> hit_three ==
            events.access[BFPC_PORT_XIP])
        else $error("code 0x11 not mapped to xip access");

    periph_contend_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        sel_two_r == 5'h00 |-> hit_two ==
            events.contended[BFPC_PORT_PERIPH])
        else $error("code 0x00 not contended peripheral port");

    dead_three_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        sel_three_r > BFPC_SEL_LAST |-> !hit_three)
        else $error("out of range code counted on three");

    sel_pad_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready &&
            {s_axi_araddr[7:2], 2'b00} == BFPC_OFS_SELECT_TWO)
        |=> s_axi_rdata[31:BFPC_SEL_W] == 27'h0)
        else $error("selector read upper bits not zero");

    clear_three_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        (wreq.wr && wreq.addr == BFPC_OFS_COUNT_THREE)
        |=> count_three == BFPC_COUNT_RST)
        else $error("counter three not cleared by write");

endmodule : bfpc_top

// file: tb/bfpc_arb_model.sv
// Arbiter event source model for the perf counter bench
`timescale 1ns/10ps
module bfpc_arb_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [19:0] pat,
    output bfpc_pkg::bfpc_events_s events
);
    import bfpc_pkg::*;
    // Registered like real arbiters; idle ports raise no event
    always_ff @(posedge ref_clk)
    begin
        if (rst || !run)
            events <= '0;
        else
            events <= bfpc_events_s'(pat);
    end
endmodule : bfpc_arb_model

// file: tb/bus_fabric_perf_counters_bench.sv
// Self-checking bench for the bus fabric perf counters
`timescale 1ns/10ps
module bus_fabric_perf_counters_bench;
    import bfpc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic [19:0] pat = '0;
    bfpc_events_s events;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    // Reference model state: counts and selector codes
    int cnt[2] = '{0, 0};
    logic [4:0] sel[2] = '{5'h1F, 5'h1F};
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    logic [15:0] seed = 16'h3C2A;
    logic [31:0] d;
    logic [1:0] r;

    bfpc_top uut (.ref_clk, .rst, .events, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    bfpc_arb_model arb (.ref_clk, .rst, .run, .pat, .events);

    always #2 ref_clk = ~ref_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Code to event: pairs per port, odd code means every access
    function automatic bit hit(input logic [4:0] c, input bfpc_events_s e);
        if (c > 5'h13)
            return 1'b0;
        return c[0] ? e.access[c[4:1]] : e.contended[c[4:1]];
    endfunction : hit

    // Reference count; saturates rather than wrapping
    always @(posedge ref_clk)
    begin
        cyc++;
        for (int k = 0; k < 2; k++)
            if (!rst && hit(sel[k], events) && cnt[k] < 32'hFFFFFF)
                cnt[k]++;
        if (cyc == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : chk

    // Write: both halves offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        bit aw;
        bit w;
        bit done;
        aw = 1'b1;
        w = 1'b1;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge ref_clk);
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                done = 1'b1;
                s_axi_bready <= 1'b0;
            end
            if (aw && s_axi_awready)
            begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready)
            begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask : axw

    // Read: address held until taken, rready until data seen
    task automatic axr(input logic [7:0] a);
        bit ar;
        bit done;
        ar = 1'b1;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge ref_clk);
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                done = 1'b1;
                s_axi_rready <= 1'b0;
            end
            if (ar && s_axi_arready)
            begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask : axr

    // Random event bursts; arbiters go quiet before any bus access
    task automatic burst(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            seed = lfsr(lfsr(seed));
            run <= seed[0] | seed[5];
            pat <= {seed[3:0], seed};
        end
        @(posedge ref_clk);
        run <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : burst

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        // Step -1 shows reset values and the idle code after a burst
        for (int c = -1; c < 22; c++)
        begin
            if (c >= 0)
            begin
                sel[0] = 5'(c);
                sel[1] = 5'(21 - c);
                axw(8'h1C, {27'h7FFFFFF, sel[0]});
                chk({32'h0, r}, {32'h0, BFPC_RESP_OKAY});
                axw(8'h24, {27'h7FFFFFF, sel[1]});
                seed = lfsr(seed);
                axw(8'h18, {seed, seed});
                axw(8'h20, 32'h0);
                cnt[0] = 0;
                cnt[1] = 0;
            end
            burst(40);
            for (int k = 0; k < 4; k++)
            begin
                axr(8'h18 + 8'(4 * k));
                if (k[0])
                    chk({r, d}, {29'h0, sel[k / 2]});
                else
                    chk({r, d}, {2'h0, 32'(cnt[k / 2])});
            end
            $display("code step %0d done", c);
        end
        // Selector needs its low lane; counter clear ignores lanes
        s_axi_wstrb <= 4'hE;
        axw(8'h1C, 32'h0);
        axr(8'h1C);
        chk({r, d}, {29'h0, sel[0]});
        s_axi_wstrb <= 4'h0;
        axw(8'h20, 32'h0);
        cnt[1] = 0;
        axr(8'h20);
        chk({r, d}, 34'h0);
        s_axi_wstrb <= 4'hF;
        $display("lane test done");
        // Unmapped offsets answer with an error and no data
        axr(8'h28);
        chk({r, d}, {2'h2, 32'h0});
        axw(8'h2C, 32'hFFFFFFFF);
        chk({r, 32'h0}, {2'h2, 32'h0});
        $display("unmapped access done");
        tally_and_finish();
    end
endmodule : bus_fabric_perf_counters_bench
